// [logic/aux_branch_defines.vh]
`ifndef AUX_BRANCH_DEFINES_VH
`define AUX_BRANCH_DEFINES_VH
`define BRANCH_AUX_NONZERO_OPCODE 9'h1f7
`define OPC_HI 15
`define OPC_LO 7
`define IND_BIT 7
`define NEXT_PTR_FLAG 3
`define PTR_FIELD_HI 2
`define PTR_FIELD_LO 0
`define MOD_HI 6
`define MOD_LO 4
`define MOD_NONE 3'h0
`define MOD_DEC 3'h1
`define MOD_INC 3'h2
`define MOD_IDX_DEC 3'h5
`define MOD_IDX_INC 3'h6
`define NUM_AUX 8
`define PTR_W 3
`define DATA_W 16
`define AUX_STEP 16'h0001
`define PROGRAM_COUNTER_STEP 16'h0002
`define PROGRAM_COUNTER_RESET 16'h0000
`define AUX_RESET 16'h0000
`define PTR_RESET 3'h0
`define WORD_RESET 16'h0000
`endif

// [logic/aux_reg_cell.v]
`timescale 1ns/10ps
`default_nettype none
`include "aux_branch_defines.vh"
module aux_reg_cell (
    input wire core_clk,
    input wire rst,
    input wire ce,
    input wire wr_en,
    input wire [15:0] wr_data,
    output reg [15:0] value
);
    always @(posedge core_clk) begin
        if (rst) begin
            value <= `AUX_RESET;
        end else if (ce && wr_en) begin
            value <= wr_data;
        end
    end
endmodule
`default_nettype wire

// [logic/aux_reg_loop_branch.v]
`timescale 1ns/10ps
`default_nettype none
`include "aux_branch_defines.vh"
module aux_reg_loop_branch (
    input wire core_clk,
    input wire rst,
    input wire ce,
    input wire instr_valid,
    input wire [15:0] instr_word,
    input wire [15:0] target_word,
    output wire instr_match,
    output reg [15:0] program_counter,
    output reg [2:0] aux_register_pointer,
    output reg branch_taken,
    output reg done,
    output wire [15:0] auxiliary_register
);
    // ==========================================
    // States
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_EXEC = 2'b10;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [15:0] op_word;
    reg [15:0] next_op_word;
    reg [15:0] op_target;
    reg [15:0] next_op_target;
    reg [15:0] next_pc;
    reg [2:0] next_ptr;
    reg next_taken;
    reg next_done;
    reg aux_write;
    // ==========================================
    // Register file nets
    wire [127:0] aux_flat;
    reg [7:0] aux_sel;
    wire [7:0] aux_wr;
    reg [15:0] cur_aux;
    wire [15:0] idx_aux;
    reg [15:0] next_aux;
    reg [2:0] mod_ptr;
    // ==========================================
    // Operand fields
    wire ind_mode;
    wire [2:0] mod_sel;
    wire ptr_load;
    wire [2:0] ptr_field;
    wire cur_zero;
    wire [15:0] dec_val;
    wire [15:0] inc_val;
    wire [15:0] idx_sub_val;
    wire [15:0] idx_add_val;
    wire [15:0] fall_address;
    // ==========================================
    // Decode
    // opcode field compare
    assign instr_match = instr_valid && (instr_word[`OPC_HI:`OPC_LO] == `BRANCH_AUX_NONZERO_OPCODE);
    assign ind_mode = op_word[`IND_BIT];
    assign mod_sel = op_word[`MOD_HI:`MOD_LO];
    assign ptr_load = op_word[`NEXT_PTR_FLAG];
    assign ptr_field = op_word[`PTR_FIELD_HI:`PTR_FIELD_LO];
    // ==========================================
    // Pointer select
    always @* begin
        aux_sel = 8'h00;
        case (aux_register_pointer)
            3'h0: aux_sel = 8'h01;
            3'h1: aux_sel = 8'h02;
            3'h2: aux_sel = 8'h04;
            3'h3: aux_sel = 8'h08;
            3'h4: aux_sel = 8'h10;
            3'h5: aux_sel = 8'h20;
            3'h6: aux_sel = 8'h40;
            3'h7: aux_sel = 8'h80;
            default: aux_sel = 8'h00;
        endcase
    end
    // ==========================================
    // Register file
    genvar g;
    generate
        for (g = 0; g < `NUM_AUX; g = g + 1) begin : gen_aux
            assign aux_wr[g] = aux_write && aux_sel[g];
            aux_reg_cell u_cell (
                .core_clk(core_clk),
                .rst(rst),
                .ce(ce),
                .wr_en(aux_wr[g]),
                .wr_data(next_aux),
                .value(aux_flat[g*16 +: 16])
            );
        end
    endgenerate
    // ==========================================
    // Read mux
    always @* begin
        cur_aux = 16'h0000;
        case (aux_register_pointer)
            3'h0: cur_aux = aux_flat[15:0];
            3'h1: cur_aux = aux_flat[31:16];
            3'h2: cur_aux = aux_flat[47:32];
            3'h3: cur_aux = aux_flat[63:48];
            3'h4: cur_aux = aux_flat[79:64];
            3'h5: cur_aux = aux_flat[95:80];
            3'h6: cur_aux = aux_flat[111:96];
            3'h7: cur_aux = aux_flat[127:112];
            default: cur_aux = 16'h0000;
        endcase
    end
    // ==========================================
    // Index and outputs
    // Index register is always register zero
    assign idx_aux = aux_flat[15:0];
    assign auxiliary_register = cur_aux;
    assign cur_zero = (cur_aux == 16'h0000);
    // ==========================================
    // Step candidates
    // sums wrap modulo 65536
    assign dec_val = cur_aux - `AUX_STEP;
    assign inc_val = cur_aux + `AUX_STEP;
    assign idx_sub_val = cur_aux - idx_aux;
    assign idx_add_val = cur_aux + idx_aux;
    assign fall_address = program_counter + `PROGRAM_COUNTER_STEP;
    // ==========================================
    // Modification
    always @* begin
        next_aux = dec_val;
        mod_ptr = aux_register_pointer;
        if (ind_mode) begin
            case (mod_sel)
                `MOD_NONE: next_aux = dec_val;
                `MOD_DEC: next_aux = dec_val;
                `MOD_INC: next_aux = inc_val;
                `MOD_IDX_DEC: next_aux = idx_sub_val;
                `MOD_IDX_INC: next_aux = idx_add_val;
                default: next_aux = dec_val;
            endcase
            if (ptr_load) begin
                mod_ptr = ptr_field;
            end
        end else begin
            // direct field gives no modification field; register is still decremented by one
            next_aux = dec_val;
        end
    end
    // ==========================================
    // Sequencer
    always @* begin
        next_state = state;
        next_op_word = op_word;
        next_op_target = op_target;
        next_pc = program_counter;
        next_ptr = aux_register_pointer;
        next_taken = branch_taken;
        next_done = 1'b0;
        aux_write = 1'b0;
        case (state)
            ST_IDLE: begin
                if (instr_match) begin
                    next_op_word = instr_word;
                    next_op_target = target_word;
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (!cur_zero) begin
                    next_pc = op_target;
                    next_taken = 1'b1;
                end else begin
                    next_pc = fall_address;
                    next_taken = 1'b0;
                end
                aux_write = 1'b1;
                next_ptr = mod_ptr;
                next_done = 1'b1;
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end
    // ==========================================
    // Control registers
    always @(posedge core_clk) begin
        if (rst) begin
            state <= ST_IDLE;
            branch_taken <= 1'b0;
            done <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            branch_taken <= next_taken;
            done <= next_done;
        end
    end
    // ==========================================
    // Operand capture
    always @(posedge core_clk) begin
        if (rst) begin
            op_word <= `WORD_RESET;
            op_target <= `WORD_RESET;
        end else if (ce) begin
            op_word <= next_op_word;
            op_target <= next_op_target;
        end
    end
    // ==========================================
    // Program registers
    always @(posedge core_clk) begin
        if (rst) begin
            program_counter <= `PROGRAM_COUNTER_RESET;
            aux_register_pointer <= `PTR_RESET;
        end else if (ce) begin
            program_counter <= next_pc;
            aux_register_pointer <= next_ptr;
        end
    end
endmodule
`default_nettype wire

// [sim/aux_branch_chk_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
// ====================
// Branch checks
module aux_branch_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [15:0] target_word,
    input wire logic instr_match,
    input wire logic [15:0] program_counter,
    input wire logic [2:0] aux_register_pointer,
    input wire logic branch_taken,
    input wire logic done,
    input wire logic [15:0] auxiliary_register
);
default clocking @(posedge core_clk); endclocking
default disable iff (rst);
a_match_decode: assert property (instr_match == (instr_valid && instr_word[15:7] == 9'h1f7))
    else $error("decode wrong");
a_done_cause: assert property (done |-> $past(instr_match, 2) ##1 !done)
    else $error("done wrong");
a_branch_load: assert property (done && $past(auxiliary_register, 2) != 16'h0000 |->
    program_counter == $past(target_word, 2) && branch_taken)
    else $error("taken wrong");
a_fall_through: assert property (done && $past(auxiliary_register, 2) == 16'h0000 |->
    program_counter == $past(program_counter, 2) + 16'h0002 && !branch_taken)
    else $error("fall wrong");
a_default_dec: assert property (done && $past(instr_word[7:3], 2) == 5'h10 |->
    auxiliary_register == $past(auxiliary_register, 2) - 16'h0001)
    else $error("dec wrong");
a_inc_wrap: assert property (done && $past(instr_word[7:3], 2) == 5'h14 |->
    auxiliary_register == $past(auxiliary_register, 2) + 16'h0001)
    else $error("inc wrong");
a_ptr_load: assert property (done && $past(instr_word[7], 2) && $past(instr_word[3], 2) |->
    aux_register_pointer == $past(instr_word[2:0], 2))
    else $error("ptr load wrong");
a_ptr_keep: assert property (done && !($past(instr_word[7], 2) && $past(instr_word[3], 2)) |->
    aux_register_pointer == $past(aux_register_pointer, 2))
    else $error("ptr keep wrong");
endmodule
bind aux_reg_loop_branch aux_branch_chk chk_u (.core_clk, .rst, .instr_valid, .instr_word, .target_word,
    .instr_match, .program_counter, .aux_register_pointer, .branch_taken, .done, .auxiliary_register);
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
// ====================
// Bench
module testbench;
reg core_clk = 1'b0;
reg rst = 1'b1;
reg iv = 1'b0;
reg [15:0] iw = 16'h0000;
reg [15:0] tw = 16'h0000;
reg ce = 1'b1;
wire m, tk, dn;
wire [15:0] prog_cnt, aux_val;
wire [2:0] ptr;
integer errors = 0;
integer compares = 0;
integer cycles = 0;
aux_reg_loop_branch dut_u (.core_clk(core_clk), .rst(rst), .ce(ce), .instr_valid(iv), .instr_word(iw),
    .target_word(tw), .instr_match(m), .program_counter(prog_cnt), .aux_register_pointer(ptr),
    .branch_taken(tk), .done(dn), .auxiliary_register(aux_val));
always #5 core_clk = ~core_clk;
task complete_run;
    if (errors == 0 && compares > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
        errors = errors + 1;
        complete_run;
    end
end
task check(input string nm, input [15:0] seen, input [15:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
        errors = errors + 1;
        $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
endtask
task run(input [15:0] i, input [15:0] t, input [15:0] epc, input [15:0] ear, input etk);
    @(posedge core_clk);
    iv <= 1'b1;
    iw <= i;
    tw <= t;
    #1;
    check("match", m, 16'h0001);
    @(posedge core_clk);
    iv <= 1'b0;
    @(posedge core_clk);
    #1;
    check("done", dn, 16'h0001);
    check("counter", prog_cnt, epc);
    check("taken", tk, etk);
    check("aux", aux_val, ear);
endtask
task s_count;
    run(16'hfb80, 16'h1234, 16'h0002, 16'hffff, 1'b0);
    run(16'hfb90, 16'h1234, 16'h1234, 16'hfffe, 1'b1);
    run(16'hfba0, 16'h0040, 16'h0040, 16'hffff, 1'b1);
    run(16'hfba0, 16'h0050, 16'h0050, 16'h0000, 1'b1);
    run(16'hfba0, 16'h0060, 16'h0052, 16'h0001, 1'b0);
endtask
task s_index;
    run(16'hfbe0, 16'h0100, 16'h0100, 16'h0002, 1'b1);
    run(16'hfbd0, 16'h0200, 16'h0200, 16'h0000, 1'b1);
    run(16'hfb89, 16'h0300, 16'h0202, 16'h0000, 1'b0);
    check("ptr", ptr, 16'h0001);
    run(16'hfbe0, 16'h0400, 16'h0204, 16'hffff, 1'b0);
    run(16'hfbe0, 16'h0500, 16'h0500, 16'hfffe, 1'b1);
endtask
task s_bad;
    @(posedge core_clk);
    iv <= 1'b1;
    iw <= 16'hfc80;
    #1;
    check("match", m, 16'h0000);
    @(posedge core_clk);
    iv <= 1'b0;
    @(posedge core_clk);
    #1;
    check("idle", dn, 16'h0000);
    check("hold", prog_cnt, 16'h0500);
endtask
task s_freeze;
    @(posedge core_clk);
    ce <= 1'b0;
    iv <= 1'b1;
    iw <= 16'hfb80;
    tw <= 16'h0700;
    repeat (3) @(posedge core_clk);
    #1;
    check("frozen done", dn, 16'h0000);
    check("frozen counter", prog_cnt, 16'h0500);
    check("frozen aux", aux_val, 16'hfffe);
    @(posedge core_clk);
    iv <= 1'b0;
    ce <= 1'b1;
endtask
task s_refuse;
    @(posedge core_clk);
    iv <= 1'b1;
    iw <= 16'hfb90;
    tw <= 16'h0600;
    repeat (2) @(posedge core_clk);
    iv <= 1'b0;
    #1;
    check("first done", dn, 16'h0001);
    check("first counter", prog_cnt, 16'h0600);
    @(posedge core_clk);
    #1;
    check("refused done", dn, 16'h0000);
    check("refused aux", aux_val, 16'hfffd);
    run(16'hfbf0, 16'h0700, 16'h0700, 16'hfffc, 1'b1);
endtask
initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    s_count;
    s_index;
    s_bad;
    s_freeze;
    s_refuse;
    complete_run;
end
endmodule
`default_nettype wire
